// >>> rtl/rtcraf_top.v
// RTC timekeeping register file with alarm match and interrupt pin
`timescale 1ns/10ps
`include "rtcraf_defs.vh"
module rtcraf_top #(
  parameter TICK_CYCLES = `RTCRAF_TICK_CYCLES,
  parameter CNT_W = 21
) (
  input wire clk_i,
  input wire resetn_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire clock_read_active_i,
  input wire backup_mode_i,
  input wire power_restored_i,
  input wire battery_low_i,
  input wire watchdog_expired_i,
  output reg [7:0] reg_rdata_o,
  output reg interrupt_pin_o,
  output reg interrupt_pin_oe_o,
  output reg square_wave_enable_o,
  output reg [3:0] square_wave_rate_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  reg rst_meta_n;
  reg rst_n;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // BCD helpers
  function [7:0] bcd_next;
    input [7:0] v;
    input [7:0] vmax;
    input [7:0] vmin;
    begin
      if (v >= vmax)
        bcd_next = vmin;
      else if (v[3:0] == 4'h9)
        bcd_next = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_next = v + 8'h01;
    end
  endfunction
  // Last day of month; leap years assumed every fourth year
  function [7:0] month_last;
    input [7:0] mon;
    input [7:0] yr;
    reg leap;
    begin
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      if (mon == `RTCRAF_BCD_FEB)
        month_last = leap ? `RTCRAF_BCD_29 : `RTCRAF_BCD_28;
      else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
        month_last = `RTCRAF_BCD_30;
      else
        month_last = `RTCRAF_BCD_31;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire wr_clk = reg_wr_i && (reg_addr_i <= `RTCRAF_A_CLK_LAST);
  wire rd_clk = reg_rd_i && (reg_addr_i <= `RTCRAF_A_CLK_LAST);
  wire rd_flags = reg_rd_i && (reg_addr_i == `RTCRAF_A_FLAGS);

  ////////////////////////////////////////////////////////////////////////////
  // Control and alarm registers, binary and BCD as written, except sqw_reg, which keeps only its high nibble
  reg [7:0] ctrl_reg;
  reg [7:0] wdog_reg;
  reg [7:0] al_mon;
  reg [7:0] alarm_day_of_month;
  reg [7:0] alarm_hour_freeze;
  reg [7:0] alarm_minutes;
  reg [7:0] alarm_seconds;
  reg [7:0] sqw_reg;
  wire freeze_updates = alarm_hour_freeze[`RTCRAF_B_HT];
  wire alarm_pin_enable = al_mon[`RTCRAF_B_AFE];
  wire backup_alarm_enable = al_mon[`RTCRAF_B_ABE];
  // Power-up clears all enables; freeze set when power returns
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= 8'h00;
      wdog_reg <= 8'h00;
      al_mon <= 8'h00;
      alarm_day_of_month <= 8'h00;
      alarm_hour_freeze <= 8'h00;
      alarm_minutes <= 8'h00;
      alarm_seconds <= 8'h00;
      sqw_reg <= 8'h00;
    end else begin
      if (reg_wr_i) begin
        case (reg_addr_i)
          `RTCRAF_A_CTRL: ctrl_reg <= reg_wdata_i;
          `RTCRAF_A_WDOG: wdog_reg <= reg_wdata_i;
          `RTCRAF_A_AL_MON: al_mon <= reg_wdata_i;
          `RTCRAF_A_ALARM_DAY_OF_MONTH: alarm_day_of_month <= reg_wdata_i;
          `RTCRAF_A_ALARM_HOUR_FREEZE: alarm_hour_freeze <= reg_wdata_i;
          `RTCRAF_A_ALARM_MINUTES: alarm_minutes <= reg_wdata_i;
          `RTCRAF_A_ALARM_SECONDS: alarm_seconds <= reg_wdata_i;
          `RTCRAF_A_SQW: sqw_reg <= reg_wdata_i & `RTCRAF_M_SQW;
          default: ;
        endcase
      end
      // Restore wins over a simultaneous host write
      if (power_restored_i)
        alarm_hour_freeze[`RTCRAF_B_HT] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hundredth-second prescaler, held at zero while the oscillator is halted
  reg osc_halt;
  reg [CNT_W-1:0] presc;
  reg tick;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      presc <= {CNT_W{1'b0}};
      tick <= 1'b0;
    end else if (osc_halt) begin
      presc <= {CNT_W{1'b0}};
      tick <= 1'b0;
    end else if (presc == TICK_CYCLES[CNT_W-1:0] - 1'b1) begin
      presc <= {CNT_W{1'b0}};
      tick <= 1'b1;
    end else begin
      presc <= presc + 1'b1;
      tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal working copies of the time counters
  reg [7:0] i_hs;
  reg [7:0] i_sec;
  reg [7:0] i_min;
  reg [7:0] i_hour;
  reg [7:0] i_dow;
  reg [7:0] i_date;
  reg [7:0] i_mon;
  reg [7:0] i_year;
  reg ceb;
  reg cb;
  reg sec_event;
  reg upd_pend;
  wire transfer = upd_pend && !freeze_updates && !clock_read_active_i && !rd_clk;
  // A host write to a clock byte skips that tick so fields never mix
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      i_hs <= 8'h00;
      i_sec <= 8'h00;
      i_min <= 8'h00;
      i_hour <= 8'h00;
      i_dow <= 8'h01;
      i_date <= 8'h01;
      i_mon <= 8'h01;
      i_year <= 8'h00;
      ceb <= 1'b0;
      cb <= 1'b0;
      osc_halt <= 1'b0;
      sec_event <= 1'b0;
      upd_pend <= 1'b0;
    end else begin
      sec_event <= 1'b0;
      if (transfer)
        upd_pend <= 1'b0;
      if (wr_clk) begin
        case (reg_addr_i)
          `RTCRAF_A_SUBSEC: i_hs <= reg_wdata_i;
          `RTCRAF_A_SEC: begin
            i_sec <= reg_wdata_i & `RTCRAF_M_7B;
            osc_halt <= reg_wdata_i[`RTCRAF_B_OSC_HALT];
          end
          `RTCRAF_A_MIN: i_min <= reg_wdata_i & `RTCRAF_M_7B;
          `RTCRAF_A_HOUR: begin
            i_hour <= reg_wdata_i & `RTCRAF_M_6B;
            ceb <= reg_wdata_i[`RTCRAF_B_CEB];
            cb <= reg_wdata_i[`RTCRAF_B_CB];
          end
          `RTCRAF_A_DOW: i_dow <= reg_wdata_i & `RTCRAF_M_DOW;
          `RTCRAF_A_DATE: i_date <= reg_wdata_i & `RTCRAF_M_DATE;
          `RTCRAF_A_MON: i_mon <= reg_wdata_i & `RTCRAF_M_MON;
          default: i_year <= reg_wdata_i;
        endcase
      end else if (tick) begin
        upd_pend <= 1'b1;
        i_hs <= bcd_next(i_hs, `RTCRAF_BCD_99, `RTCRAF_BCD_ZERO);
        if (i_hs == `RTCRAF_BCD_99) begin
          sec_event <= 1'b1;
          i_sec <= bcd_next(i_sec, `RTCRAF_BCD_59, `RTCRAF_BCD_ZERO);
          if (i_sec == `RTCRAF_BCD_59) begin
            i_min <= bcd_next(i_min, `RTCRAF_BCD_59, `RTCRAF_BCD_ZERO);
            if (i_min == `RTCRAF_BCD_59) begin
              i_hour <= bcd_next(i_hour, `RTCRAF_BCD_23, `RTCRAF_BCD_ZERO);
              if (i_hour == `RTCRAF_BCD_23) begin
                i_dow <= bcd_next(i_dow, `RTCRAF_BCD_7, `RTCRAF_BCD_ONE);
                i_date <= bcd_next(i_date, month_last(i_mon, i_year), `RTCRAF_BCD_ONE);
                if (i_date == month_last(i_mon, i_year)) begin
                  i_mon <= bcd_next(i_mon, `RTCRAF_BCD_12, `RTCRAF_BCD_ONE);
                  if (i_mon == `RTCRAF_BCD_12) begin
                    i_year <= bcd_next(i_year, `RTCRAF_BCD_99, `RTCRAF_BCD_ZERO);
                    if (i_year == `RTCRAF_BCD_99 && ceb)
                      cb <= ~cb;
                  end
                end
              end
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // User copies of the eight clock bytes
  reg [7:0] ucopy [0:7];
  wire [7:0] icopy [0:7];
  assign icopy[0] = i_hs;
  assign icopy[1] = {osc_halt, i_sec[6:0]};
  assign icopy[2] = i_min;
  assign icopy[3] = {ceb, cb, i_hour[5:0]};
  assign icopy[4] = i_dow;
  assign icopy[5] = i_date;
  assign icopy[6] = i_mon;
  assign icopy[7] = i_year;
  // All bytes load together; a host write lands on its own byte, masked like the counter
  localparam [63:0] UCOPY_WMASK = `RTCRAF_M_CLOCK_BYTES;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_ucopy
      always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
          ucopy[gi] <= (gi >= 4 && gi <= 6) ? 8'h01 : 8'h00;
        else if (wr_clk && reg_addr_i[2:0] == gi)
          ucopy[gi] <= reg_wdata_i & UCOPY_WMASK[gi*8 +: 8];
        else if (transfer)
          ucopy[gi] <= icopy[gi];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Alarm compare against the working copy, one cycle after each second
  wire [4:0] repeat_code = {alarm_day_of_month[`RTCRAF_B_RPT5], alarm_day_of_month[`RTCRAF_B_RPT4],
                            alarm_hour_freeze[`RTCRAF_B_RPT3], alarm_minutes[`RTCRAF_B_RPT2],
                            alarm_seconds[`RTCRAF_B_RPT1]};
  wire m_sec = (alarm_seconds[6:0] == i_sec[6:0]);
  wire m_min = (alarm_minutes[6:0] == i_min[6:0]);
  wire m_hour = (alarm_hour_freeze[5:0] == i_hour[5:0]);
  wire m_date = (alarm_day_of_month[5:0] == i_date[5:0]);
  wire m_mon = (al_mon[4:0] == i_mon[4:0]);
  reg alarm_match;
  always @* begin
    case (repeat_code)
      `RTCRAF_RPT_MIN: alarm_match = m_sec;
      `RTCRAF_RPT_HOUR: alarm_match = m_sec && m_min;
      `RTCRAF_RPT_DAY: alarm_match = m_sec && m_min && m_hour;
      `RTCRAF_RPT_MONTH: alarm_match = m_sec && m_min && m_hour && m_date;
      `RTCRAF_RPT_YEAR: alarm_match = m_sec && m_min && m_hour && m_date && m_mon;
      default: alarm_match = 1'b1;
    endcase
  end
  // Zeroed date with year code never matches a valid date
  reg alarm_chk;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n)
      alarm_chk <= 1'b0;
    else
      alarm_chk <= sec_event;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: hardware set wins over clear-on-read
  reg alarm_flag;
  reg watchdog_expired_flag;
  reg battery_weak_flag;
  wire alarm_set = alarm_chk && alarm_match;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alarm_flag <= 1'b0;
      watchdog_expired_flag <= 1'b0;
      battery_weak_flag <= 1'b0;
    end else begin
      battery_weak_flag <= battery_low_i;
      if (alarm_set)
        alarm_flag <= 1'b1;
      else if (rd_flags)
        alarm_flag <= 1'b0;
      if (watchdog_expired_i)
        watchdog_expired_flag <= 1'b1;
      else if (rd_flags)
        watchdog_expired_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain interrupt pin, square-wave outputs, read data
  wire next_irq = (alarm_flag && !rd_flags) && alarm_pin_enable
                  && (!backup_mode_i || backup_alarm_enable);
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_pin_o <= 1'b0;
      interrupt_pin_oe_o <= 1'b0;
      square_wave_enable_o <= 1'b0;
      square_wave_rate_o <= 4'h0;
      reg_rdata_o <= 8'h00;
    end else begin
      interrupt_pin_o <= 1'b0;
      interrupt_pin_oe_o <= next_irq || alarm_set && alarm_pin_enable
                            && (!backup_mode_i || backup_alarm_enable);
      square_wave_enable_o <= al_mon[`RTCRAF_B_SQUARE_WAVE_ENABLE];
      square_wave_rate_o <= sqw_reg[7:4];
      if (reg_rd_i) begin
        case (reg_addr_i)
          `RTCRAF_A_SUBSEC, `RTCRAF_A_SEC, `RTCRAF_A_MIN, `RTCRAF_A_HOUR,
          `RTCRAF_A_DOW, `RTCRAF_A_DATE, `RTCRAF_A_MON, `RTCRAF_A_YEAR:
            reg_rdata_o <= ucopy[reg_addr_i[2:0]];
          `RTCRAF_A_CTRL: reg_rdata_o <= ctrl_reg;
          `RTCRAF_A_WDOG: reg_rdata_o <= wdog_reg;
          `RTCRAF_A_AL_MON: reg_rdata_o <= al_mon;
          `RTCRAF_A_ALARM_DAY_OF_MONTH: reg_rdata_o <= alarm_day_of_month;
          `RTCRAF_A_ALARM_HOUR_FREEZE: reg_rdata_o <= alarm_hour_freeze;
          `RTCRAF_A_ALARM_MINUTES: reg_rdata_o <= alarm_minutes;
          `RTCRAF_A_ALARM_SECONDS: reg_rdata_o <= alarm_seconds;
          `RTCRAF_A_FLAGS: reg_rdata_o <= {watchdog_expired_flag, alarm_flag, 1'b0,
                                           battery_weak_flag, 4'h0};
          `RTCRAF_A_SQW: reg_rdata_o <= sqw_reg;
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule // rtcraf_top

// >>> rtl/rtcraf_defs.vh
// Constants for the RTC register file and alarm block
`ifndef RTCRAF_DEFS_VH
`define RTCRAF_DEFS_VH

// Register byte addresses
`define RTCRAF_A_SUBSEC     8'h00
`define RTCRAF_A_SEC        8'h01
`define RTCRAF_A_MIN        8'h02
`define RTCRAF_A_HOUR       8'h03
`define RTCRAF_A_DOW        8'h04
`define RTCRAF_A_DATE       8'h05
`define RTCRAF_A_MON        8'h06
`define RTCRAF_A_YEAR       8'h07
`define RTCRAF_A_CTRL       8'h08
`define RTCRAF_A_WDOG       8'h09
`define RTCRAF_A_AL_MON     8'h0a
`define RTCRAF_A_ALARM_DAY_OF_MONTH    8'h0b
`define RTCRAF_A_ALARM_HOUR_FREEZE    8'h0c
`define RTCRAF_A_ALARM_MINUTES     8'h0d
`define RTCRAF_A_ALARM_SECONDS     8'h0e
`define RTCRAF_A_FLAGS      8'h0f
`define RTCRAF_A_SQW        8'h13
`define RTCRAF_A_CLK_LAST   8'h07

// Writable bit masks (fixed-zero positions cleared)
`define RTCRAF_M_DOW        8'h07
`define RTCRAF_M_DATE       8'h3f
`define RTCRAF_M_MON        8'h1f
`define RTCRAF_M_7B         8'h7f
`define RTCRAF_M_6B         8'h3f
`define RTCRAF_M_SQW        8'hf0
// Per-byte write masks of the eight clock bytes, byte 0 lowest
`define RTCRAF_M_CLOCK_BYTES 64'hff1f3f07ff7fffff

// Bit positions
`define RTCRAF_B_OSC_HALT   7
`define RTCRAF_B_CEB        7
`define RTCRAF_B_CB         6
`define RTCRAF_B_AFE        7
`define RTCRAF_B_SQUARE_WAVE_ENABLE       6
`define RTCRAF_B_ABE        5
`define RTCRAF_B_RPT4       7
`define RTCRAF_B_RPT5       6
`define RTCRAF_B_RPT3       7
`define RTCRAF_B_HT         6
`define RTCRAF_B_RPT2       7
`define RTCRAF_B_RPT1       7

// Repeat codes, RPT5..RPT1
`define RTCRAF_RPT_SEC      5'h1f
`define RTCRAF_RPT_MIN      5'h1e
`define RTCRAF_RPT_HOUR     5'h1c
`define RTCRAF_RPT_DAY      5'h18
`define RTCRAF_RPT_MONTH    5'h10
`define RTCRAF_RPT_YEAR     5'h00

// BCD limits
`define RTCRAF_BCD_ZERO     8'h00
`define RTCRAF_BCD_ONE      8'h01
`define RTCRAF_BCD_99       8'h99
`define RTCRAF_BCD_59       8'h59
`define RTCRAF_BCD_23       8'h23
`define RTCRAF_BCD_7        8'h07
`define RTCRAF_BCD_12       8'h12
`define RTCRAF_BCD_28       8'h28
`define RTCRAF_BCD_29       8'h29
`define RTCRAF_BCD_30       8'h30
`define RTCRAF_BCD_31       8'h31
`define RTCRAF_BCD_FEB      8'h02

// Timing: hundredth-second tick at 125 MHz
`define RTCRAF_CLK_PERIOD_NS 8
`define RTCRAF_TICK_NS       10000000
`define RTCRAF_TICK_CYCLES   (`RTCRAF_TICK_NS / `RTCRAF_CLK_PERIOD_NS)

`endif

// >>> verif/rtcraf_top_asserts.sv
// Port checker for the RTC register file and alarm block
`timescale 1ns/10ps
module rtcraf_top_asserts (
  input wire clk_i,
  input wire resetn_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire backup_mode_i,
  input wire [7:0] reg_rdata_o,
  input wire interrupt_pin_o,
  input wire interrupt_pin_oe_o,
  input wire [3:0] square_wave_rate_o,
  input wire square_wave_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  reg afe_q;
  reg abe_q;
  reg [7:0] ctrl_q;
  reg ctrl_v;
  wire rd_flags = reg_rd_i && reg_addr_i == 8'h0f;
  wire wr_en = reg_wr_i && reg_addr_i == 8'h0a;
  //////////////////////////////////////////////////
  // Shadows of enables and control byte; power-up clears the enables
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      afe_q <= 1'b0;
      abe_q <= 1'b0;
      ctrl_v <= 1'b0;
      ctrl_q <= 8'h00;
    end else begin
      if (wr_en) begin
        afe_q <= reg_wdata_i[7];
        abe_q <= reg_wdata_i[5];
      end
      if (reg_wr_i && reg_addr_i == 8'h08) begin
        ctrl_q <= reg_wdata_i;
        ctrl_v <= 1'b1;
      end
    end
  end
  // Pin data is only ever low; the enable alone asserts it
  pin_od_a: assert property (interrupt_pin_o == 1'b0)
    else $error("interrupt data not low");
  flag_bits_a: assert property (rd_flags |=> (reg_rdata_o & 8'h2f) == 8'h00)
    else $error("flags spare bits set");
  rsvd_zero_a: assert property (reg_rd_i && reg_addr_i >= 8'h10 && reg_addr_i <= 8'h12
    |=> reg_rdata_o == 8'h00) else $error("reserved byte not zero");
  sqw_low_a: assert property (reg_rd_i && reg_addr_i == 8'h13 |=> reg_rdata_o[3:0] == 4'h0)
    else $error("rate byte low nibble set");
  flag_clear_a: assert property (rd_flags |=> !interrupt_pin_oe_o)
    else $error("pin held after flags read");
  // The pin is launched from the enables as they stood one edge earlier
  oe_cause_a: assert property ($rose(interrupt_pin_oe_o) |-> $past(afe_q)
    && (!$past(backup_mode_i) || $past(abe_q))) else $error("pin asserted without enables");
  oe_hold_a: assert property (interrupt_pin_oe_o && !rd_flags && !$past(wr_en)
    && $stable(backup_mode_i) |=> interrupt_pin_oe_o)
    else $error("pin released without flags read");
  sqw_rate_a: assert property (reg_wr_i && reg_addr_i == 8'h13 |=> ##1
    square_wave_rate_o == $past(reg_wdata_i[7:4], 2)) else $error("rate output wrong");
  sqw_en_a: assert property (wr_en |=> ##1 square_wave_enable_o == $past(reg_wdata_i[6], 2))
    else $error("square enable output wrong");
  ctrl_rb_a: assert property (reg_rd_i && reg_addr_i == 8'h08 && ctrl_v |=> reg_rdata_o == ctrl_q)
    else $error("control readback wrong");
  // Main scenarios reached
  oe_rise_c: cover property ($rose(interrupt_pin_oe_o));
  flag_rd_c: cover property (rd_flags && interrupt_pin_oe_o);
  bk_rise_c: cover property ($rose(interrupt_pin_oe_o) && backup_mode_i);
endmodule // rtcraf_top_asserts

bind rtcraf_top rtcraf_top_asserts chk_u (.clk_i(clk_i), .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .backup_mode_i(backup_mode_i), .reg_rdata_o(reg_rdata_o),
  .interrupt_pin_o(interrupt_pin_o), .interrupt_pin_oe_o(interrupt_pin_oe_o),
  .square_wave_rate_o(square_wave_rate_o), .square_wave_enable_o(square_wave_enable_o));

// >>> verif/rtcraf_host.sv
// Host model: microcontroller driving the byte register port
`timescale 1ns/10ps
module rtcraf_host (
  input wire clk_i,
  input wire [7:0] rdata_i,
  output reg [7:0] addr_o,
  output reg [7:0] wdata_o,
  output reg wr_o,
  output reg rd_o
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  //////////////////////////////////////////////////
  // One byte write; data is scrambled once released so nothing leans on it
  task wr(input [7:0] ad, input [7:0] d);
    begin
      @(posedge clk_i);
      addr_o <= ad;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
    end
  endtask
  // One byte read; data taken once settled, it holds until the next read
  task rd(input [7:0] ad, output [7:0] d);
    begin
      @(posedge clk_i);
      addr_o <= ad;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      @(posedge clk_i);
      #1 d = rdata_i;
    end
  endtask
endmodule // rtcraf_host

// >>> verif/rtc_register_file_alarm_tb.sv
// Self-checking testbench for the RTC register file and alarm block
`timescale 1ns/10ps
module rtc_register_file_alarm_tb;
  reg clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg clock_read_active_i = 1'b0;
  reg backup_mode_i = 1'b0;
  reg power_restored_i = 1'b0;
  reg battery_low_i = 1'b0;
  reg watchdog_expired_i = 1'b0;
  wire [7:0] addr;
  wire [7:0] wdata;
  wire [7:0] rdata;
  wire wr;
  wire rd;
  wire pin;
  wire pin_oe;
  wire sqw_en;
  wire [3:0] sqw_rate;
  integer fail_count = 0;
  integer total_checks = 0;
  integer cyc = 0;
  integer t0;
  integer t1;
  reg [7:0] a;
  reg [7:0] b;
  // Clock of 8 ns and a free cycle count for timing alarm events
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  rtcraf_host host_u (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  // Short prescaler: one second is 400 cycles
  rtcraf_top #(.TICK_CYCLES(4)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .clock_read_active_i(clock_read_active_i), .backup_mode_i(backup_mode_i),
    .power_restored_i(power_restored_i), .battery_low_i(battery_low_i),
    .watchdog_expired_i(watchdog_expired_i), .reg_rdata_o(rdata), .interrupt_pin_o(pin),
    .interrupt_pin_oe_o(pin_oe), .square_wave_enable_o(sqw_en), .square_wave_rate_o(sqw_rate));
  //////////////////////////////////////////////////
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  task check(input [7:0] got, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rdc(input [7:0] ad, input [7:0] ex);
    begin
      host_u.rd(ad, a);
      check(a, ex);
    end
  endtask
  task idle(input integer n);
    begin
      repeat (n) @(posedge clk_i);
    end
  endtask
  // Bounded wait for the pin; a lost alarm ends the run
  task wait_oe(output integer t);
    integer n;
    begin
      n = 0;
      while (pin_oe !== 1'b1 && n < 1000) begin
        @(posedge clk_i);
        #1 n = n + 1;
      end
      t = cyc;
      if (pin_oe !== 1'b1) begin
        fail_count = fail_count + 1;
        $display("Error at %0t: alarm timeout", $time);
        print_verdict;
      end
    end
  endtask
  //////////////////////////////////////////////////
  // Power-up state of enables, flags and calendar
  task t_reset;
    begin
      rdc(8'h0a, 8'h00);
      rdc(8'h05, 8'h01);
      rdc(8'h0f, 8'h00);
      $display("reset test done");
    end
  endtask
  // Binary field registers, fixed-zero nibble and reserved places
  task t_fields;
    begin
      host_u.wr(8'h08, 8'ha5);
      host_u.wr(8'h09, 8'h7e);
      host_u.wr(8'h13, 8'hb0);
      host_u.wr(8'h0a, 8'h40);
      host_u.wr(8'h07, 8'h99);
      rdc(8'h08, 8'ha5);
      rdc(8'h09, 8'h7e);
      rdc(8'h13, 8'hb0);
      check({4'h0, sqw_rate}, 8'h0b);
      check({7'h00, sqw_en}, 8'h01);
      rdc(8'h11, 8'h00);
      rdc(8'h14, 8'h00);
      rdc(8'h07, 8'h99);
      host_u.wr(8'h0a, 8'h00);
      $display("fields test done");
    end
  endtask
  // Watchdog and battery flags; the read clears only the event flag
  task t_flags;
    begin
      @(posedge clk_i);
      battery_low_i <= 1'b1;
      watchdog_expired_i <= 1'b1;
      @(posedge clk_i);
      watchdog_expired_i <= 1'b0;
      rdc(8'h0f, 8'h90);
      rdc(8'h0f, 8'h10);
      @(posedge clk_i);
      battery_low_i <= 1'b0;
      $display("flags test done");
    end
  endtask
  // Two alarm events must lie exactly one second apart
  task period(input [7:0] d);
    begin
      host_u.wr(8'h0b, d);
      host_u.rd(8'h0f, a);
      wait_oe(t0);
      rdc(8'h0f, 8'h40);
      check({7'h00, pin_oe}, 8'h00);
      wait_oe(t1);
      host_u.rd(8'h0f, a);
      check(8'(t1 - t0 - 300), 8'h64);
    end
  endtask
  // Once per second, an unlisted code, back-up gating, then disable
  task t_alarm;
    begin
      host_u.wr(8'h0e, 8'h80);
      host_u.wr(8'h0d, 8'h80);
      host_u.wr(8'h0c, 8'h80);
      host_u.wr(8'h0a, 8'h80);
      period(8'hc0);
      period(8'h40);
      @(posedge clk_i);
      backup_mode_i <= 1'b1;
      host_u.rd(8'h0f, a);
      idle(900);
      check({7'h00, pin_oe}, 8'h00);
      rdc(8'h0f, 8'h40);
      host_u.wr(8'h0a, 8'ha0);
      wait_oe(t0);
      @(posedge clk_i);
      backup_mode_i <= 1'b0;
      host_u.wr(8'h0b, 8'h00);
      host_u.wr(8'h0c, 8'h00);
      host_u.wr(8'h0d, 8'h00);
      host_u.wr(8'h0e, 8'h00);
      host_u.rd(8'h0f, a);
      idle(900);
      check({7'h00, pin_oe}, 8'h00);
      rdc(8'h0f, 8'h00);
      host_u.wr(8'h0a, 8'h00);
      $display("alarm test done");
    end
  endtask
  // Frozen copies after power return and during a clock read burst
  task t_freeze;
    begin
      @(posedge clk_i);
      power_restored_i <= 1'b1;
      @(posedge clk_i);
      power_restored_i <= 1'b0;
      rdc(8'h0c, 8'h40);
      host_u.rd(8'h01, b);
      idle(500);
      rdc(8'h01, b);
      host_u.wr(8'h0c, 8'h00);
      idle(500);
      host_u.rd(8'h01, a);
      check({7'h00, a == b}, 8'h00);
      @(posedge clk_i);
      clock_read_active_i <= 1'b1;
      host_u.rd(8'h01, b);
      idle(500);
      rdc(8'h01, b);
      @(posedge clk_i);
      clock_read_active_i <= 1'b0;
      $display("freeze test done");
    end
  endtask
  // Oscillator halt holds seconds; clearing it restarts counting
  task t_halt;
    begin
      host_u.wr(8'h00, 8'h00);
      host_u.wr(8'h01, 8'h80);
      idle(500);
      rdc(8'h01, 8'h80);
      host_u.wr(8'h01, 8'h00);
      idle(500);
      host_u.rd(8'h01, a);
      check({7'h00, a == 8'h00}, 8'h00);
      $display("halt test done");
    end
  endtask
  // Last hundredth of the century rolls every field; century bit toggles
  task t_century;
    begin
      host_u.wr(8'h00, 8'h00);
      host_u.wr(8'h07, 8'h99);
      host_u.wr(8'h06, 8'h12);
      host_u.wr(8'h05, 8'h31);
      host_u.wr(8'h03, 8'ha3);
      host_u.wr(8'h02, 8'h59);
      host_u.wr(8'h01, 8'h59);
      host_u.wr(8'h00, 8'h99);
      idle(20);
      rdc(8'h03, 8'hc0);
      rdc(8'h07, 8'h00);
      rdc(8'h05, 8'h01);
      $display("century test done");
    end
  endtask
  // Main sequence
  initial begin
    idle(16);
    resetn_i <= 1'b1;
    idle(3);
    t_reset;
    t_fields;
    t_flags;
    t_alarm;
    t_freeze;
    t_halt;
    t_century;
    print_verdict;
  end
endmodule // rtc_register_file_alarm_tb
